// [src/ombc_top.sv]
// operating mode and bus configuration block with apb slave
//
// Overview of operation
// RL1: mode pins 100..111 give modes 4..7
// RL2: bit 10 reads zero always
// RL3: extended modes hold bus enable at one
// RL4: single-chip bus enable resets zero, writable
// RL5: software idles bus before clearing enable
// RL6: bus enable bit gates external bus
// RL7: ram enable resets one; zero disables ram
// RL8: software avoids clearing ram enable mid-access
// RL9: bits 7..2 read zero always
// RL10: transfer mode bit resets one, selects addressing
// RL11: bit 0 reads one always
// RL12: modes 4,5 advanced, rom disabled
// RL13: mode 4 starts sixteen bit, ports DEF/HI
// RL14: mode 4 all-eight-bit areas narrow bus
// RL15: modes 4-6 ports A,B carry control
// RL16: modes 5,6 widen on any sixteen-bit area
// RL17: modes 6,7 rom on; mode 6 ddr addresses
// RL18: mode 7 external space closed until enabled
// RL19: mode 7 enabled ports follow ddr
// RL20: modes 1,2 act as mode 7
// RL21: gated region external or reserved by enable
// RL22: ram disabled maps ram region external
// RL23: software avoids reserved regions, keeps ram
// RL24: modes 4-6 extended, 7 single-chip
`timescale 1ns/10ps
module ombc_top
  import ombc_pkg::*;
#(
  parameter int AREAS = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // apb request
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  // apb answer
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // mode pins
  input wire logic [2:0] mode_pins,
  // address classification request
  input wire logic rgn_gated,
  input wire logic rgn_ram,
  // region class of the current address
  output logic [1:0] rgn_class_q,
  // system control copies
  output logic ext_bus_enable_q,
  output logic onchip_ram_enable_q,
  output logic xfer_ctrl_addr_mode_q,
  // mode-derived status
  output logic rom_enable_q,
  output logic advanced_mode_q,
  output logic bus_wide_q,
  // port pin functions
  output ombc_pinfn_t pinfn_q
);
  // latched mode
  ombc_mode_t mode_q;
  // system control flops, with the bus enable next value
  logic ext_d;
  logic ext_q;
  logic ram_q;
  logic xfer_q;
  // bus controller and port direction model
  logic [AREAS-1:0] area16_q;
  logic [2:0] ddr_q;
  logic init_q;
  // combinational results
  logic [31:0] sys_word;
  logic [31:0] rdata_d;
  ombc_pinfn_t pinfn_d;

  // address compare, shared by every register select
  function automatic logic addr_is(input logic [11:0] a, input logic [11:0] ofs);
    addr_is = (a == ofs);
  endfunction : addr_is

  // mode decoder
  ombc_mode_dec u_mode (
    .clk(clk),
    .rst_n(rst_n),
    .mode_pins(mode_pins),
    .mode_q(mode_q)
  );

  // mode groups taken from the latched one-hot mode
  wire mode_known = (mode_q != OMBC_MODE_BAD);
  wire m1 = (mode_q == OMBC_MODE_1);
  wire m2 = (mode_q == OMBC_MODE_2);
  wire m4 = (mode_q == OMBC_MODE_4);
  wire m5 = (mode_q == OMBC_MODE_5);
  wire m6 = (mode_q == OMBC_MODE_6);
  wire m7 = (mode_q == OMBC_MODE_7);
  // boot modes behave as the single-chip mode
  wire boot_mode = m1 | m2; // RL20
  wire m45 = m4 | m5; // RL12
  wire extended = m45 | m6; // RL24
  wire single_chip = m7 | boot_mode; // RL20 RL24
  // on-chip rom off where the processor runs from outside, and with an unknown mode
  wire rom_on = mode_known & ~m45; // RL12 RL17
  // width that the bus takes right after reset
  wire start16 = m4; // RL13

  // apb phases
  wire setup = psel & ~penable;
  wire acc = psel & penable;
  wire wr = acc & pwrite;
  wire rd_setup = setup & ~pwrite;
  // register selects on the byte address
  wire sel_sys = addr_is(paddr, OMBC_SYSCTL_OFS);
  wire sel_mode = addr_is(paddr, OMBC_MODE_OFS);
  wire sel_area = addr_is(paddr, OMBC_AREA_OFS);
  wire sel_ddr = addr_is(paddr, OMBC_DDR_OFS);
  wire sel_stat = addr_is(paddr, OMBC_STAT_OFS);
  wire hit = sel_sys | sel_mode | sel_area | sel_ddr | sel_stat;
  // writes commit in the access phase only
  wire wr_sys = wr & sel_sys;
  wire wr_area = wr & sel_area;
  wire wr_ddr = wr & sel_ddr;

  // bus enable next value: fixed in extended modes, free in single-chip
  // modes; an unknown pin pattern keeps the bus closed
  wire ext_wr = wr_sys & single_chip; // RL4
  wire ext_wval = pwdata[OMBC_BIT_EXT];
  assign ext_d = extended ? 1'b1 // RL3
               : ext_wr ? ext_wval // RL4
               : ext_q;

  // bus enable flop
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ext_q <= OMBC_EXT_RST_SINGLE; // RL4
    end else begin
      ext_q <= ext_d;
    end
  end

  // ram enable flop, back to one on every reset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ram_q <= OMBC_RAM_RST; // RL7
    end else if (wr_sys) begin
      ram_q <= pwdata[OMBC_BIT_RAM]; // RL7 RL22
    end
  end

  // transfer controller address mode flop
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      xfer_q <= OMBC_XFER_RST; // RL10
    end else if (wr_sys) begin
      xfer_q <= pwdata[OMBC_BIT_XFER]; // RL10
    end
  end

  // seeding flag: set once the latched mode is known
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      init_q <= 1'b0;
    end else if (mode_known) begin
      init_q <= 1'b1;
    end
  end

  // seed value per mode, then per-area width bits from software
  wire seed = ~init_q & mode_known;
  wire [AREAS-1:0] area_seed = start16 ? AREAS'(OMBC_AREA16_RST_M4) : AREAS'(OMBC_AREA16_RST_OTHER); // RL13 RL18
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      area16_q <= '0;
    end else if (seed) begin
      area16_q <= area_seed;
    end else if (wr_area) begin
      area16_q <= pwdata[AREAS-1:0];
    end
  end

  // port direction bits, cleared by reset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ddr_q <= OMBC_DDR_RST;
    end else if (wr_ddr) begin
      ddr_q <= pwdata[2:0];
    end
  end

  // system control word: reserved bits tied, live bits from the flops
  always_comb begin
    sys_word = 32'h0000_0000;
    sys_word[OMBC_BIT_RSV10] = 1'b0; // RL2
    sys_word[OMBC_BIT_EXT] = ext_q;
    sys_word[OMBC_BIT_RAM] = ram_q;
    sys_word[7:2] = 6'h00; // RL9
    sys_word[OMBC_BIT_XFER] = xfer_q;
    sys_word[OMBC_BIT_RSV0] = 1'b1; // RL11
  end
  // the other words, zero-extended to the bus
  wire [31:0] mode_word = {25'h000_0000, mode_q};
  wire [31:0] area_word = 32'(area16_q);
  wire [31:0] ddr_word = {29'h0000_0000, ddr_q};
  wire [31:0] stat_word = {27'h000_0000, rom_enable_q, advanced_mode_q, bus_wide_q, ext_q, ram_q};
  // one-hot and-or read selection, zero on unmapped addresses
  assign rdata_d = ({32{sel_sys}} & sys_word)
                 | ({32{sel_mode}} & mode_word)
                 | ({32{sel_area}} & area_word)
                 | ({32{sel_ddr}} & ddr_word)
                 | ({32{sel_stat}} & stat_word);

  // pready: one access cycle after every setup, so no wait states
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pready <= 1'b0;
    end else begin
      pready <= setup;
    end
  end

  // pslverr: flags an unmapped address with the same pulse
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= setup & ~hit;
    end
  end

  // prdata: zero outside read answers so stale words never show
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
    end else begin
      prdata <= rd_setup ? rdata_d : 32'h0000_0000;
    end
  end

  // bus width per mode
  wire any16 = |area16_q;
  wire all8 = ~any16;
  // mode 4 narrows only when all areas are 8-bit; others widen on any 16-bit area
  wire wide_m4 = ~all8; // RL13 RL14
  wire wide_other = any16; // RL16
  wire wide = start16 ? wide_m4 : wide_other;
  // external side reachable only with a known mode and the enable set
  wire ext_open = ext_q & mode_known; // RL6 RL18

  // port groups: control on A/B, address on D/E/F, data on H and I
  wire ddr_addr = ddr_q[0];
  wire ddr_data_h = ddr_q[1];
  wire ddr_data_i = ddr_q[2];
  // address pins: fixed in modes 4 and 5, per direction bits otherwise
  wire addr_fixed = m45; // RL13
  wire addr_by_ddr = ext_open & ddr_addr & (m6 | single_chip); // RL17 RL19
  // data pins: H fixed once the bus is open in the extended modes, I only while the bus is also wide
  wire data_h_on = ext_open & (extended | ddr_data_h); // RL16 RL19
  wire data_i_on = ext_open & wide & (extended | ddr_data_i); // RL14 RL19
  // pin function selection
  always_comb begin
    pinfn_d = '0;
    pinfn_d.ctrl_ab = extended; // RL15
    pinfn_d.addr_def = addr_fixed | addr_by_ddr; // RL13 RL17 RL19
    pinfn_d.addr_ddr = ddr_addr;
    pinfn_d.data_h = data_h_on;
    pinfn_d.data_i = data_i_on;
  end

  // region classification: ram region first, then the gated region
  wire [1:0] ram_cls = ram_q ? OMBC_RGN_INTERNAL : OMBC_RGN_EXTERNAL; // RL22
  wire [1:0] gate_cls = ext_q ? OMBC_RGN_EXTERNAL : OMBC_RGN_RESERVED; // RL21
  // anything else stays on-chip
  wire [1:0] rgn_d = rgn_ram ? ram_cls
                   : rgn_gated ? gate_cls
                   : OMBC_RGN_INTERNAL;

  // region class output
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rgn_class_q <= OMBC_RGN_INTERNAL;
    end else begin
      rgn_class_q <= rgn_d;
    end
  end

  // bus enable copy
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ext_bus_enable_q <= 1'b0;
    end else begin
      ext_bus_enable_q <= ext_q; // RL6
    end
  end

  // ram enable copy
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      onchip_ram_enable_q <= OMBC_RAM_RST;
    end else begin
      onchip_ram_enable_q <= ram_q; // RL7
    end
  end

  // transfer controller mode copy
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      xfer_ctrl_addr_mode_q <= OMBC_XFER_RST;
    end else begin
      xfer_ctrl_addr_mode_q <= xfer_q; // RL10
    end
  end

  // on-chip rom enable
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rom_enable_q <= 1'b0;
    end else begin
      rom_enable_q <= rom_on; // RL12 RL17
    end
  end

  // advanced processor mode for every known mode
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      advanced_mode_q <= 1'b0;
    end else begin
      advanced_mode_q <= mode_known; // RL12
    end
  end

  // external bus width
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bus_wide_q <= 1'b0;
    end else begin
      bus_wide_q <= wide;
    end
  end

  // port pin functions
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pinfn_q <= '0;
    end else begin
      pinfn_q <= pinfn_d;
    end
  end
endmodule : ombc_top

// [src/ombc_pkg.sv]
// package for operating mode and bus configuration block
package ombc_pkg;
  // register map (byte addresses on apb)
  localparam logic [11:0] OMBC_SYSCTL_OFS = 12'h000;
  localparam logic [11:0] OMBC_MODE_OFS = 12'h004;
  localparam logic [11:0] OMBC_AREA_OFS = 12'h008;
  localparam logic [11:0] OMBC_DDR_OFS = 12'h00C;
  localparam logic [11:0] OMBC_STAT_OFS = 12'h010;
  // system control field positions
  localparam int OMBC_BIT_RSV10 = 10;
  localparam int OMBC_BIT_EXT = 9;
  localparam int OMBC_BIT_RAM = 8;
  localparam int OMBC_BIT_XFER = 1;
  localparam int OMBC_BIT_RSV0 = 0;
  // reset values
  localparam logic OMBC_RAM_RST = 1'h1;
  localparam logic OMBC_XFER_RST = 1'h1;
  localparam logic OMBC_EXT_RST_SINGLE = 1'h0;
  localparam logic [7:0] OMBC_AREA16_RST_M4 = 8'hFF;
  localparam logic [7:0] OMBC_AREA16_RST_OTHER = 8'h00;
  localparam logic [2:0] OMBC_DDR_RST = 3'h0;
  // memory region classes
  localparam logic [1:0] OMBC_RGN_INTERNAL = 2'h0;
  localparam logic [1:0] OMBC_RGN_EXTERNAL = 2'h1;
  localparam logic [1:0] OMBC_RGN_RESERVED = 2'h2;
  // decoded operating mode, one-hot
  typedef enum logic [6:0] {
    OMBC_MODE_1 = 7'h01,
    OMBC_MODE_2 = 7'h02,
    OMBC_MODE_4 = 7'h04,
    OMBC_MODE_5 = 7'h08,
    OMBC_MODE_6 = 7'h10,
    OMBC_MODE_7 = 7'h20,
    OMBC_MODE_BAD = 7'h40
  } ombc_mode_t;
  // pin function set for the ports
  typedef struct packed {
    logic ctrl_ab;
    logic addr_def;
    logic addr_ddr;
    logic data_h;
    logic data_i;
  } ombc_pinfn_t;
  // decode the three mode pins
  function automatic ombc_mode_t ombc_decode(input logic [2:0] pins);
    case (pins)
      3'h1: ombc_decode = OMBC_MODE_1;
      3'h2: ombc_decode = OMBC_MODE_2;
      3'h4: ombc_decode = OMBC_MODE_4;
      3'h5: ombc_decode = OMBC_MODE_5;
      3'h6: ombc_decode = OMBC_MODE_6;
      3'h7: ombc_decode = OMBC_MODE_7;
      default: ombc_decode = OMBC_MODE_BAD;
    endcase
  endfunction : ombc_decode
endpackage : ombc_pkg

// [src/ombc_mode_dec.sv]
// operating mode decoder, latched once after reset
`timescale 1ns/10ps
module ombc_mode_dec
  import ombc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // mode pins
  input wire logic [2:0] mode_pins,
  // decoded mode
  output ombc_mode_t mode_q
);
  logic taken_q;
  // capture mode pins in first cycle after reset release
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      taken_q <= 1'b0;
      mode_q <= OMBC_MODE_BAD;
    end else if (!taken_q) begin
      taken_q <= 1'b1;
      mode_q <= ombc_decode(mode_pins); // RL1
    end
  end
endmodule : ombc_mode_dec

// [verification/ombc_props.sv]
// assertions for the mode and bus configuration block
`timescale 1ns/10ps
module ombc_props
  import ombc_pkg::*;
#(
  parameter int AREAS = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // apb answer side
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // region classification
  input wire logic rgn_gated,
  input wire logic rgn_ram,
  input wire logic [1:0] rgn_class_q,
  // configuration outputs
  input wire logic ext_bus_enable_q,
  input wire logic onchip_ram_enable_q,
  input wire logic xfer_ctrl_addr_mode_q,
  input wire logic rom_enable_q,
  input wire logic advanced_mode_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // read answer of the system control word
  wire sysrd = pready && !pwrite && !pslverr && paddr == OMBC_SYSCTL_OFS;
  // register read and reset relations
  a_rsv_zero: assert property (sysrd |-> prdata[10] == 0 && prdata[7:2] == 0)
    else $error("reserved bits not zero");
  a_bit0_one: assert property (sysrd |-> prdata[0])
    else $error("bit 0 not one");
  a_ext_copy: assert property (sysrd |-> prdata[9] == ext_bus_enable_q)
    else $error("bus enable output differs");
  a_ram_copy: assert property (sysrd |-> prdata[8] == onchip_ram_enable_q && prdata[1] == xfer_ctrl_addr_mode_q)
    else $error("ram or transfer output differs");
  a_ram_reset: assert property ($rose(rst_n) |-> onchip_ram_enable_q && xfer_ctrl_addr_mode_q)
    else $error("reset value wrong");
  a_ext_held: assert property ((advanced_mode_q && !rom_enable_q)[*3] |-> ext_bus_enable_q)
    else $error("bus enable dropped in extended mode");
  // address map gating
  a_region_gate: assert property (rgn_gated && !rgn_ram |=>
    rgn_class_q == ($past(ext_bus_enable_q) ? OMBC_RGN_EXTERNAL : OMBC_RGN_RESERVED))
    else $error("gated region class wrong");
  a_ram_remap: assert property (rgn_ram |=>
    rgn_class_q == ($past(onchip_ram_enable_q) ? OMBC_RGN_INTERNAL : OMBC_RGN_EXTERNAL))
    else $error("ram region class wrong");
  // main scenarios reached
  cover property (sysrd && !prdata[9]);
  cover property (rgn_class_q == OMBC_RGN_RESERVED);
  cover property (pslverr);
endmodule : ombc_props

bind ombc_top ombc_props #(.AREAS(AREAS)) ombc_props_inst (.*);

// [verification/ombc_addr_src.sv]
// far-side address source that flags the region of each access
`timescale 1ns/10ps
module ombc_addr_src (
  // clock
  input wire logic clk,
  // region pick, bit 1 gated, bit 0 ram
  input wire logic [1:0] req,
  // region flags to the block
  output logic rgn_gated,
  output logic rgn_ram
);
  // flags change only just after a clock edge
  always_ff @(posedge clk) begin
    {rgn_gated, rgn_ram} <= req;
  end
endmodule : ombc_addr_src

// [verification/operating_mode_bus_config_test.sv]
// bench for the mode and bus configuration block
`timescale 1ns/10ps
module operating_mode_bus_config_test;
  import ombc_pkg::*;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr, rgn_gated, rgn_ram, err, x;
  logic ext_bus_enable_q, onchip_ram_enable_q, xfer_ctrl_addr_mode_q, rom_enable_q, advanced_mode_q, bus_wide_q;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0] mode_pins, m;
  logic [1:0] rgn_class_q, req;
  ombc_pinfn_t pinfn_q;
  logic [2:0] ml [6] = '{3'h4, 3'h5, 3'h6, 3'h7, 3'h1, 3'h2};
  logic [6:0] mh [6] = '{7'h04, 7'h08, 7'h10, 7'h20, 7'h01, 7'h02};
  int fails = 0;
  int n_tests = 0;
  int cyc = 0;
  ombc_top ombc_top_inst (.*);
  ombc_addr_src ombc_addr_src_inst (.*);
  // clock
  initial begin
    clk = 0;
    forever #10 clk = ~clk;
  end
  // hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fails++;
      test_done;
    end
  end
  task test_done;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : test_done
  task chk(input logic [32:0] g, input logic [32:0] e);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  // one apb transfer, held until pready
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb
  task boot(input logic [2:0] p);
    @(posedge clk);
    mode_pins <= p;
    rst_n <= 0;
    repeat (12) @(posedge clk);
    rst_n <= 1;
    repeat (4) @(posedge clk);
  endtask : boot
  task rg(input logic [1:0] r, input logic [1:0] e);
    req <= r;
    repeat (3) @(posedge clk);
    chk(rgn_class_q, e);
    req <= 0;
  endtask : rg
  task aw(input logic [31:0] d, input logic e);
    apb(1, OMBC_AREA_OFS, d);
    repeat (3) @(posedge clk);
    chk(bus_wide_q, e);
  endtask : aw
  // main sequence over all modes
  initial begin
    {psel, penable, pwrite, rst_n, req} = 0;
    paddr = 0;
    pwdata = 0;
    mode_pins = 3'h7;
    for (int i = 0; i < 6; i++) begin
      m = ml[i];
      x = m inside {3'h4, 3'h5, 3'h6};
      boot(m);
      apb(0, OMBC_SYSCTL_OFS, 0);
      chk(rd, x ? 32'h303 : 32'h103);
      apb(0, OMBC_MODE_OFS, 0);
      chk(rd, 32'(mh[i]));
      chk({rom_enable_q, advanced_mode_q, bus_wide_q}, {!(m inside {3'h4, 3'h5}), 1'b1, m == 3'h4});
      chk({pinfn_q.ctrl_ab, pinfn_q.addr_def, pinfn_q.data_h}, {x, m inside {3'h4, 3'h5}, x});
      apb(1, OMBC_SYSCTL_OFS, 32'h4FE);
      apb(0, OMBC_SYSCTL_OFS, 0);
      chk(rd, x ? 32'h203 : 32'h003);
      rg(2'b01, OMBC_RGN_EXTERNAL);
      rg(2'b10, x ? OMBC_RGN_EXTERNAL : OMBC_RGN_RESERVED);
      apb(1, OMBC_SYSCTL_OFS, 32'h303);
      rg(2'b10, OMBC_RGN_EXTERNAL);
      rg(2'b01, OMBC_RGN_INTERNAL);
      apb(1, OMBC_SYSCTL_OFS, 32'h301);
      repeat (3) @(posedge clk);
      chk({ext_bus_enable_q, onchip_ram_enable_q, xfer_ctrl_addr_mode_q}, 3'h6);
      aw(32'h01, 1);
      apb(1, OMBC_DDR_OFS, 32'h7);
      repeat (3) @(posedge clk);
      chk({pinfn_q.addr_def, pinfn_q.addr_ddr, pinfn_q.data_h, pinfn_q.data_i}, 4'hF);
      aw(32'h00, 0);
      chk(pinfn_q.data_i, 0);
      $display("mode %0d done", m);
    end
    apb(0, 12'h020, 32'h0);
    chk({err, rd}, 33'h100000000);
    $display("unmapped access done");
    test_done;
  end
endmodule : operating_mode_bus_config_test
